// ==== optical_sensor_data_fifo_readout.sv ====

// ==========================================
// Staging buffer between front end and sample store
module sample_stage_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  // State of the buffer, ready kept as a flop
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
    logic rdy;
  } fifo_state_t;
  localparam fifo_state_t F_RST = fifo_state_t'({{($bits(fifo_state_t) - 1){1'b0}}, 1'b1});
  fifo_state_t q_ff; // Registered state
  fifo_state_t nxt_q; // Next state
  logic push; // Word accepted
  logic pop; // Word drained

  assign in_ready_out = q_ff.rdy;
  assign out_valid_out = (q_ff.count != '0);
  assign out_data_out = q_ff.mem[q_ff.rptr];

  // Next state of pointers and count
  always_comb begin
    nxt_q = q_ff;
    push = in_valid_in & q_ff.rdy;
    pop = (q_ff.count != '0) & out_ready_in;
    if (push) begin
      nxt_q.mem[q_ff.wptr] = in_data_in;
      nxt_q.wptr = (q_ff.wptr == PW'(DEPTH - 1)) ? '0 : q_ff.wptr + 1'b1;
    end
    if (pop) begin
      nxt_q.rptr = (q_ff.rptr == PW'(DEPTH - 1)) ? '0 : q_ff.rptr + 1'b1;
    end
    nxt_q.count = q_ff.count + CW'(push) - CW'(pop);
    nxt_q.rdy = (nxt_q.count != CW'(DEPTH));
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_ff <= F_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end
endmodule : sample_stage_fifo

// ==========================================
// Sensor result registers and sample store
module optical_sensor_data_fifo_readout #(
  parameter logic [7:0] FACTORY_TRIM_IR = sensor_readout_pkg::RST_TRIM,
  parameter logic [7:0] FACTORY_TRIM_RED = sensor_readout_pkg::RST_TRIM,
  parameter int STAGE_DEPTH = 32
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic link_clk_in,
  input wire logic link_sel_in,
  input wire logic link_addr_in,
  input wire logic link_wr_in,
  input wire logic link_rd_in,
  input wire logic [7:0] link_wdata_in,
  output logic [7:0] rdata_out,
  output logic rdata_valid_out,
  input wire logic light_valid_in,
  input wire logic [119:0] light_raw_in,
  input wire logic prox_valid_in,
  input wire logic [15:0] prox_raw_in,
  input wire logic sample_valid_in,
  output logic sample_ready_out,
  input wire logic [23:0] sample_data_in,
  output logic light_conv_en_out,
  output logic prox_conv_en_out,
  output logic pulse_conv_en_out,
  output logic dual_mode_out,
  output logic standby_out
);
  localparam int CH_W = sensor_readout_pkg::CH_W;
  localparam int DK = sensor_readout_pkg::DARK_CH;
  localparam int SLOTS = sensor_readout_pkg::SLOTS;
  localparam int PTR_W = $clog2(SLOTS);
  localparam int LW = sensor_readout_pkg::LINK_W;
  // Control bytes within the settings block
  localparam int ADDR_L = int'(sensor_readout_pkg::ADDR_CTRL_LIGHT -
                               sensor_readout_pkg::ADDR_SET_FIRST);
  localparam int ADDR_P = int'(sensor_readout_pkg::ADDR_CTRL_PULSE -
                               sensor_readout_pkg::ADDR_SET_FIRST);

  // ==========================================
  // Whole state of the block
  typedef struct packed {
    logic [LW-1:0] sync1; // First synchroniser stage
    logic [LW-1:0] sync2; // Second synchroniser stage
    logic clk_prev; // Link clock history
    logic [7:0] ptr; // Internal address pointer
    logic [1:0] byte_idx; // Byte within a sample
    logic [7:0] rdata; // Read byte
    logic rvalid; // Read byte strobe
    logic [7:0] stat0; // Status byte 0
    logic [7:0] stat1; // Status byte 1
    logic [15:0] prox; // Proximity result
    logic [119:0] light; // Light channel results
    logic [sensor_readout_pkg::SET_N-1:0][7:0] set; // Settings bytes
    logic [7:0] trim_ir; // Infrared trim
    logic [7:0] trim_red; // Red trim
    logic [PTR_W-1:0] wp; // Sample write pointer
    logic [PTR_W-1:0] rp; // Sample read pointer
    logic [7:0] ovf; // Overflow counter
    logic pair_odd; // Red half of a pair due next
    logic [SLOTS-1:0][CH_W-1:0] ram; // Sample store
    logic light_en; // Light conversions on
    logic prox_en; // Proximity conversions on
    logic pulse_en; // Pulse conversions on
    logic dual; // Dual emitter mode
    logic standby; // Low power standby
  } state_t;

  // Power-on values of the state
  function automatic state_t init_state();
    state_t s;
    s = '0;
    s.set[sensor_readout_pkg::ADDR_HIDDEN_A - sensor_readout_pkg::ADDR_SET_FIRST] =
        sensor_readout_pkg::RST_HIDDEN_A;
    s.set[sensor_readout_pkg::ADDR_HIDDEN_B - sensor_readout_pkg::ADDR_SET_FIRST] =
        sensor_readout_pkg::RST_HIDDEN_B;
    s.set[sensor_readout_pkg::ADDR_HIDDEN_C - sensor_readout_pkg::ADDR_SET_FIRST] =
        sensor_readout_pkg::RST_HIDDEN_C;
    s.trim_ir = FACTORY_TRIM_IR;
    s.trim_red = FACTORY_TRIM_RED;
    s.standby = 1'b1;
    return s;
  endfunction : init_state

  localparam state_t ST_RESET = init_state();

  state_t q_ff; // Registered state
  state_t nxt_q; // Next state
  state_t rst_q; // Soft reset image
  logic srst; // Software or power-on reset command
  logic pulse_rdy_set; // Pulse flag set this cycle

  // ==========================================
  // Link decode from the synchronised pins
  logic link_clk_s; // Synchronised link clock
  logic sel_s; // Transaction in progress
  logic addr_s; // Address phase
  logic wr_s; // Write strobe
  logic rd_s; // Read strobe
  logic [7:0] wdata_s; // Write byte
  logic link_rise; // Link clock rising edge
  logic rd_ev; // Register read taken
  logic wr_ev; // Register write taken
  logic [7:0] ctrl_l; // Light control byte
  logic [7:0] ctrl_p; // Pulse control byte
  logic [PTR_W-1:0] unread; // Samples not yet read

  assign {link_clk_s, sel_s, addr_s, wr_s, rd_s, wdata_s} = q_ff.sync2;
  assign link_rise = link_clk_s & ~q_ff.clk_prev;
  assign rd_ev = link_rise & sel_s & ~addr_s & ~wr_s & rd_s;
  assign wr_ev = link_rise & sel_s & ~addr_s & wr_s;
  assign ctrl_l = q_ff.set[ADDR_L];
  assign ctrl_p = q_ff.set[ADDR_P];
  assign unread = q_ff.wp - q_ff.rp;

  // ==========================================
  // Front-end results
  logic [119:0] light_comp; // Dark-corrected channels
  logic [CH_W-1:0] dark; // Leakage count
  logic [23:0] prox_prod; // Trim product
  logic [16:0] prox_shift; // Product scaled back
  logic [15:0] prox_scaled; // Saturated proximity value
  logic [7:0] trim_sel; // Trim of the active emitter

  assign dark = light_raw_in[DK*CH_W +: CH_W];
  // Per channel dark subtraction, clamped at zero to stay unsigned
  for (genvar c = 0; c < DK; c++) begin : g_dark
    assign light_comp[c*CH_W +: CH_W] = (light_raw_in[c*CH_W +: CH_W] > dark) ?
        light_raw_in[c*CH_W +: CH_W] - dark : '0;
  end
  assign light_comp[DK*CH_W +: CH_W] = dark;
  assign trim_sel = ctrl_p[sensor_readout_pkg::RED_BIT] ? q_ff.trim_red : q_ff.trim_ir;
  assign prox_prod = 24'(prox_raw_in) * 24'(trim_sel);
  assign prox_shift = prox_prod[sensor_readout_pkg::TRIM_FRAC +: 17];
  assign prox_scaled = prox_shift[16] ? 16'hffff : prox_shift[15:0];

  // ==========================================
  // Staging buffer for pulse samples
  logic st_valid; // Sample waiting
  logic st_ready; // Store takes sample
  logic [23:0] st_data; // Waiting sample
  logic pop; // Sample leaves staging
  logic store_ok; // Sample goes into the store
  logic full; // Store holds 31 unread

  // Stall only while a 3-byte sample is half read, so it is never torn
  assign st_ready = ~(sel_s & (q_ff.byte_idx != 2'h0));
  assign pop = st_valid & st_ready;
  assign store_ok = pop & q_ff.pulse_en & ~sel_s;
  assign full = (PTR_W'(q_ff.wp + 1'b1) == q_ff.rp);

  sample_stage_fifo #(
    .WIDTH(24),
    .DEPTH(STAGE_DEPTH)
  ) u_stage (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(sample_valid_in),
    .in_ready_out(sample_ready_out),
    .in_data_in(sample_data_in),
    .out_valid_out(st_valid),
    .out_ready_in(st_ready),
    .out_data_out(st_data)
  );

  // Register read multiplexer over the current state
  function automatic logic [7:0] reg_read(input state_t s, input logic [7:0] a);
    logic [7:0] li;
    logic [7:0] si;
    li = a - sensor_readout_pkg::ADDR_LIGHT;
    si = a - sensor_readout_pkg::ADDR_SET_FIRST;
    reg_read = 8'h00;
    if (a == sensor_readout_pkg::ADDR_STATUS0) begin
      reg_read = s.stat0;
    end else if (a == sensor_readout_pkg::ADDR_STATUS1) begin
      reg_read = s.stat1;
    end else if (a == sensor_readout_pkg::ADDR_PROX) begin
      reg_read = s.prox[7:0];
    end else if (a == sensor_readout_pkg::ADDR_PROX + 8'h01) begin
      reg_read = s.prox[15:8];
    end else if (li < sensor_readout_pkg::LIGHT_BYTES) begin
      reg_read = s.light[int'(li)*8 +: 8];
    end else if (a >= sensor_readout_pkg::ADDR_SET_FIRST &&
                 a <= sensor_readout_pkg::ADDR_SET_LAST) begin
      reg_read = s.set[si];
    end else if (a == sensor_readout_pkg::ADDR_WR_PTR) begin
      reg_read = 8'(s.wp);
    end else if (a == sensor_readout_pkg::ADDR_RD_PTR) begin
      reg_read = 8'(s.rp);
    end else if (a == sensor_readout_pkg::ADDR_OVF) begin
      reg_read = s.ovf;
    end else if (a == sensor_readout_pkg::ADDR_DATA) begin
      reg_read = s.ram[s.rp][s.byte_idx*8 +: 8];
    end else if (a == sensor_readout_pkg::ADDR_TRIM_IR) begin
      reg_read = s.trim_ir;
    end else if (a == sensor_readout_pkg::ADDR_TRIM_RED) begin
      reg_read = s.trim_red;
    end
  endfunction : reg_read

  // ==========================================
  // Next state
  always_comb begin
    nxt_q = q_ff;
    rst_q = ST_RESET;
    srst = 1'b0;
    pulse_rdy_set = 1'b0;
    nxt_q.rvalid = 1'b0;
    nxt_q.sync1 = {link_clk_in, link_sel_in, link_addr_in, link_wr_in, link_rd_in,
                   link_wdata_in};
    nxt_q.sync2 = q_ff.sync1;
    nxt_q.clk_prev = link_clk_s;
    // Sample into the store, or dropped and counted
    if (pop && q_ff.pulse_en && sel_s) begin
      nxt_q.ovf = (q_ff.ovf == 8'hff) ? q_ff.ovf : q_ff.ovf + 8'h01;
    end else if (store_ok) begin
      nxt_q.ram[q_ff.wp] = st_data;
      nxt_q.wp = q_ff.wp + 1'b1;
      nxt_q.pair_odd = q_ff.dual & ~q_ff.pair_odd;
      pulse_rdy_set = ~q_ff.dual | q_ff.pair_odd;
      if (full) begin
        nxt_q.rp = q_ff.rp + 1'b1;
        nxt_q.ovf = (q_ff.ovf == 8'hff) ? q_ff.ovf : q_ff.ovf + 8'h01;
      end
    end
    // Address phase loads the pointer
    if (link_rise && sel_s && addr_s) begin
      nxt_q.ptr = wdata_s;
      nxt_q.byte_idx = 2'h0;
    end
    // Register write
    if (wr_ev) begin
      if (q_ff.ptr >= sensor_readout_pkg::ADDR_SET_FIRST &&
          q_ff.ptr <= sensor_readout_pkg::ADDR_SET_LAST) begin
        nxt_q.set[q_ff.ptr - sensor_readout_pkg::ADDR_SET_FIRST] = wdata_s;
      end
      if (q_ff.ptr == sensor_readout_pkg::ADDR_CTRL_LIGHT) begin
        srst = wdata_s[sensor_readout_pkg::SWRST_BIT];
      end
      if (q_ff.ptr == sensor_readout_pkg::ADDR_CTRL_PULSE) begin
        srst = wdata_s[sensor_readout_pkg::POR_BIT];
      end
      if (q_ff.ptr == sensor_readout_pkg::ADDR_WR_PTR) begin
        nxt_q.wp = wdata_s[PTR_W-1:0];
        nxt_q.pair_odd = 1'b0;
      end
      if (q_ff.ptr == sensor_readout_pkg::ADDR_RD_PTR) begin
        nxt_q.rp = wdata_s[PTR_W-1:0];
        nxt_q.byte_idx = 2'h0;
      end
      if (q_ff.ptr == sensor_readout_pkg::ADDR_OVF) begin
        nxt_q.ovf = wdata_s;
      end
      if (q_ff.ptr == sensor_readout_pkg::ADDR_TRIM_IR) begin
        nxt_q.trim_ir = wdata_s;
      end
      if (q_ff.ptr == sensor_readout_pkg::ADDR_TRIM_RED) begin
        nxt_q.trim_red = wdata_s;
      end
      if (q_ff.ptr != sensor_readout_pkg::ADDR_DATA) begin
        nxt_q.ptr = q_ff.ptr + 8'h01;
      end
    end
    // Register read and its side effects
    if (rd_ev) begin
      nxt_q.rdata = reg_read(q_ff, q_ff.ptr);
      nxt_q.rvalid = 1'b1;
      if (q_ff.ptr == sensor_readout_pkg::ADDR_STATUS0) begin
        nxt_q.stat0 = 8'h00;
      end
      if (q_ff.ptr == sensor_readout_pkg::ADDR_STATUS1) begin
        nxt_q.stat1 = 8'h00;
      end
      if (q_ff.ptr == sensor_readout_pkg::ADDR_DATA) begin
        // Data port steps through the store, not the map
        if (q_ff.byte_idx == 2'h2) begin
          nxt_q.byte_idx = 2'h0;
          if (unread != '0) begin
            nxt_q.rp = q_ff.rp + 1'b1;
          end
        end else begin
          nxt_q.byte_idx = q_ff.byte_idx + 2'h1;
        end
      end else begin
        nxt_q.ptr = q_ff.ptr + 8'h01;
      end
    end
    // Result updates, set after the read clear so the set wins
    if (light_valid_in && q_ff.light_en) begin
      nxt_q.light = light_comp;
      nxt_q.stat0[sensor_readout_pkg::LIGHT_RDY_BIT] = 1'b1;
    end
    if (prox_valid_in && q_ff.prox_en) begin
      nxt_q.prox = prox_scaled;
      nxt_q.stat1[sensor_readout_pkg::PROX_RDY_BIT] = 1'b1;
    end
    if (pulse_rdy_set) begin
      nxt_q.stat0[sensor_readout_pkg::PULSE_RDY_BIT] = 1'b1;
    end
    // Soft reset keeps only the link front end and the address pointer
    if (srst) begin
      rst_q.sync1 = nxt_q.sync1;
      rst_q.sync2 = nxt_q.sync2;
      rst_q.clk_prev = nxt_q.clk_prev;
      rst_q.ptr = nxt_q.ptr;
      nxt_q = rst_q;
    end
    // Mode outputs from the new control bytes
    nxt_q.pulse_en = nxt_q.set[ADDR_P][sensor_readout_pkg::EN_BIT] &
                     nxt_q.set[ADDR_P][sensor_readout_pkg::PULSE_SEL_BIT];
    nxt_q.prox_en = nxt_q.set[ADDR_P][sensor_readout_pkg::EN_BIT] &
                    ~nxt_q.set[ADDR_P][sensor_readout_pkg::PULSE_SEL_BIT];
    nxt_q.light_en = nxt_q.set[ADDR_L][sensor_readout_pkg::EN_BIT] & ~nxt_q.pulse_en;
    nxt_q.dual = nxt_q.set[ADDR_P][sensor_readout_pkg::DUAL_BIT];
    nxt_q.standby = ~(nxt_q.set[ADDR_L][sensor_readout_pkg::EN_BIT] |
                      nxt_q.set[ADDR_P][sensor_readout_pkg::EN_BIT]);
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_ff <= ST_RESET;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign rdata_out = q_ff.rdata;
  assign rdata_valid_out = q_ff.rvalid;
  assign light_conv_en_out = q_ff.light_en;
  assign prox_conv_en_out = q_ff.prox_en;
  assign pulse_conv_en_out = q_ff.pulse_en;
  assign dual_mode_out = q_ff.dual;
  assign standby_out = q_ff.standby;

  // ==========================================
  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_dark_channel: assert property (light_valid_in && q_ff.light_en && !srst |=>
    q_ff.light[DK*CH_W +: CH_W] == $past(dark)) else $error("dark count not reported");
  a_trim_scale: assert property (prox_valid_in && q_ff.prox_en && !srst |=>
    q_ff.prox == $past(prox_scaled)) else $error("proximity not trim scaled");
  a_standby_idle: assert property (##1 standby_out ==
    !(ctrl_l[sensor_readout_pkg::EN_BIT] || ctrl_p[sensor_readout_pkg::EN_BIT]))
    else $error("standby does not follow enables");
  a_mode_exclusive: assert property (pulse_conv_en_out |->
    !light_conv_en_out && !prox_conv_en_out) else $error("pulse mode not exclusive");
  a_soft_reset: assert property (srst |=> q_ff.trim_ir == FACTORY_TRIM_IR &&
    q_ff.ovf == 8'h00 && q_ff.wp == '0 && standby_out) else $error("soft reset incomplete");
  a_rd_advance: assert property (rd_ev && q_ff.ptr == sensor_readout_pkg::ADDR_DATA &&
    q_ff.byte_idx == 2'h2 && unread != '0 && !srst |=> q_ff.rp == $past(q_ff.rp) + 1'b1)
    else $error("read pointer did not advance");
  a_overwrite: assert property (store_ok && full && !wr_ev |=>
    q_ff.rp == $past(q_ff.rp) + 1'b1 && q_ff.wp == $past(q_ff.wp) + 1'b1)
    else $error("lapping write did not overwrite");
  a_busy_drop: assert property (pop && q_ff.pulse_en && sel_s && !wr_ev |=>
    q_ff.wp == $past(q_ff.wp) && q_ff.ovf != 8'h00) else $error("sample stored during access");
  a_ptr_hold: assert property (rd_ev && q_ff.ptr == sensor_readout_pkg::ADDR_DATA |=>
    q_ff.ptr == sensor_readout_pkg::ADDR_DATA) else $error("pointer left the data port");
  a_stat_clear: assert property (rd_ev && q_ff.ptr == sensor_readout_pkg::ADDR_STATUS1
    && !prox_valid_in |=> q_ff.stat1 == 8'h00) else $error("status not cleared by read");
  a_ready_flag: assert property (pulse_rdy_set && !srst |=>
    q_ff.stat0[sensor_readout_pkg::PULSE_RDY_BIT]) else $error("pulse ready flag missed");

endmodule : optical_sensor_data_fifo_readout

// ==== optical_sensor_data_fifo_readout_test.sv ====
// ====
// Bench for the readout block
module optical_sensor_data_fifo_readout_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in, rst_n_in, lclk, lsel, lad, lwr, lrd, rvld, lv, pv, sv, srdy;
  logic len, pen, gen, stby, dm;
  logic [7:0] lwd, rdata, q, tr;
  logic [119:0] lraw;
  logic [15:0] praw;
  logic [23:0] sd, dk, e, p;
  logic [7:0] rb [0:31];
  logic [23:0] smp [0:39];
  int errors, checks;
  optical_sensor_data_fifo_readout uut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .link_clk_in(lclk), .link_sel_in(lsel), .link_addr_in(lad), .link_wr_in(lwr),
    .link_rd_in(lrd), .link_wdata_in(lwd), .rdata_out(rdata), .rdata_valid_out(rvld),
    .light_valid_in(lv), .light_raw_in(lraw), .prox_valid_in(pv), .prox_raw_in(praw),
    .sample_valid_in(sv), .sample_ready_out(srdy), .sample_data_in(sd),
    .light_conv_en_out(len), .prox_conv_en_out(pen), .pulse_conv_en_out(gen),
    .dual_mode_out(dm), .standby_out(stby));
  sensor_host_model h (.sys_clk_in(sys_clk_in), .rdata_in(rdata), .rdata_valid_in(rvld),
    .link_clk_out(lclk), .link_sel_out(lsel), .link_addr_out(lad), .link_wr_out(lwr),
    .link_rd_out(lrd), .link_wdata_out(lwd));
  // ====
  // Shared tasks
  task automatic chk(input string n, input logic [23:0] x, input logic [23:0] g);
    checks++;
    if (g !== x) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic complete_run();
    if (errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  // Address phase, then n writes of d
  task automatic wr_n(input logic [7:0] a, input int n, input logic [7:0] d);
    h.op(1'b1, 1'b0, 1'b0, a, q);
    repeat (n) h.op(1'b0, 1'b1, 1'b0, d, q);
    h.done();
  endtask : wr_n
  // Address phase, then a burst of n reads
  task automatic rd_b(input logic [7:0] a, input int n);
    h.op(1'b1, 1'b0, 1'b0, a, q);
    for (int i = 0; i < n; i++) begin
      h.op(1'b0, 1'b0, 1'b1, 8'h00, q);
      rb[i] = q;
    end
    h.done();
  endtask : rd_b
  task automatic push(input logic [23:0] d);
    sv <= 1'b1;
    sd <= d;
    @(posedge sys_clk_in);
    while (srdy !== 1'b1) @(posedge sys_clk_in);
    sv <= 1'b0;
    @(posedge sys_clk_in);
  endtask : push
  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  // Watchdog
  initial begin
    #2000000;
    errors++;
    complete_run();
  end
  // ====
  // Main sequence
  initial begin
    {rst_n_in, lv, pv, sv} = 4'h0;
    {lraw, praw, sd} = '0;
    errors = 0;
    checks = 0;
    void'($urandom(32'h67b6));
    repeat (6) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    chk("standby", 24'h1, stby);
    rd_b(8'h19, 1);
    chk("reserved default", 24'h02, rb[0]);
    // Settings writes keep the default-one bit and spare the low three bits
    tr = 8'($urandom) | sensor_readout_pkg::RST_HIDDEN_A;
    wr_n(8'h19, 1, tr);
    rd_b(8'h19, 1);
    chk("masked setting", tr, rb[0]);
    tr = 8'($urandom) & 8'hf8;
    wr_n(8'h2f, 1, tr);
    rd_b(8'h2f, 1);
    chk("cancellation kept", tr, rb[0]);
    wr_n(8'h15, 1, 8'h01);
    chk("light enable", 24'h1, len);
    chk("standby", 24'h0, stby);
    dk = 24'($urandom_range(255, 16));
    lraw <= {dk, 24'($urandom), 24'($urandom), 24'($urandom), dk - 24'h5};
    lv <= 1'b1;
    @(posedge sys_clk_in);
    lv <= 1'b0;
    rd_b(8'h00, 19);
    chk("light ready", 24'h1, rb[0][0]);
    for (int c = 0; c < 5; c++) begin
      e = lraw[24*c +: 24];
      e = (c == 4) ? dk : ((e > dk) ? e - dk : 24'h0);
      chk("light channel", e, {rb[6+3*c], rb[5+3*c], rb[4+3*c]});
    end
    rd_b(8'h00, 1);
    chk("status cleared", 24'h0, rb[0][0]);
    tr = 8'($urandom_range(255, 129));
    wr_n(8'h42, 1, tr);
    wr_n(8'h16, 1, 8'h01);
    chk("prox enable", 24'h1, pen);
    praw <= 16'($urandom) | 16'h8000;
    pv <= 1'b1;
    @(posedge sys_clk_in);
    pv <= 1'b0;
    rd_b(8'h02, 2);
    p = (24'(praw) * 24'(tr)) >> 7;
    chk("prox", (p > 24'hffff) ? 24'hffff : p, {rb[1], rb[0]});
    wr_n(8'h16, 1, 8'h03);
    chk("pulse enable", 24'h1, gen);
    chk("light blocked", 24'h0, len);
    wr_n(8'h38, 3, 8'h00);
    for (int i = 0; i < 40; i++) smp[i] = 24'($urandom);
    for (int i = 0; i < 5; i++) push(smp[i]);
    repeat (20) @(posedge sys_clk_in);
    rd_b(8'h00, 1);
    chk("pulse ready", 24'h1, rb[0][4]);
    rd_b(8'h38, 18);
    chk("wr ptr", 24'h5, rb[0]);
    chk("rd ptr", 24'h0, rb[1]);
    for (int i = 0; i < 5; i++) begin
      chk("sample", smp[i], {rb[5+3*i], rb[4+3*i], rb[3+3*i]});
    end
    for (int i = 0; i < 40; i++) push(smp[39-i]);
    repeat (40) @(posedge sys_clk_in);
    rd_b(8'h38, 6);
    chk("wr ptr wrap", 24'hd, rb[0]);
    chk("rd ptr lapped", 24'he, rb[1]);
    chk("overflow", 24'h9, rb[2]);
    chk("oldest sample", smp[30], {rb[5], rb[4], rb[3]});
    // Dual emitter: ready only after the pair, read back as a pair
    wr_n(8'h16, 1, 8'h07);
    chk("dual mode", 24'h1, dm);
    wr_n(8'h38, 3, 8'h00);
    rd_b(8'h00, 1);
    push(smp[1]);
    repeat (4) @(posedge sys_clk_in);
    rd_b(8'h00, 1);
    chk("half pair ready", 24'h0, rb[0][4]);
    push(smp[2]);
    repeat (4) @(posedge sys_clk_in);
    rd_b(8'h00, 1);
    chk("pair ready", 24'h1, rb[0][4]);
    rd_b(8'h38, 9);
    chk("pair infrared", smp[1], {rb[5], rb[4], rb[3]});
    chk("pair red", smp[2], {rb[8], rb[7], rb[6]});
    // Sample arriving during a host access is dropped and counted
    fork
      rd_b(8'h38, 3);
      begin
        repeat (12) @(posedge sys_clk_in);
        push(smp[3]);
      end
    join
    rd_b(8'h38, 3);
    chk("busy no store", 24'h2, rb[0]);
    chk("busy drop", 24'h1, rb[2]);
    wr_n(8'h15, 1, 8'h80);
    chk("standby", 24'h1, stby);
    rd_b(8'h42, 1);
    chk("trim restored", 24'h80, rb[0]);
    // Host zeroes both trims, power-on command brings them back
    wr_n(8'h42, 2, 8'h00);
    wr_n(8'h16, 1, 8'h80);
    rd_b(8'h42, 2);
    chk("infrared trim", 24'h80, rb[0]);
    chk("red trim", 24'h80, rb[1]);
    complete_run();
  end
endmodule : optical_sensor_data_fifo_readout_test

// ==== sensor_host_model.sv ====
// ====
// Host side of the register link
module sensor_host_model (
  input wire logic sys_clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rdata_valid_in,
  output logic link_clk_out,
  output logic link_sel_out,
  output logic link_addr_out,
  output logic link_wr_out,
  output logic link_rd_out,
  output logic [7:0] link_wdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle link, clock parked low
  initial begin
    {link_clk_out, link_sel_out, link_addr_out, link_wr_out, link_rd_out} = 5'h00;
    link_wdata_out = 8'h00;
  end
  // One link cycle: pins, rising edge, answer
  task automatic op(input logic a, input logic w, input logic r,
                    input logic [7:0] d, output logic [7:0] q);
    q = 'x;
    @(posedge sys_clk_in);
    link_sel_out <= 1'b1;
    link_addr_out <= a;
    link_wr_out <= w;
    link_rd_out <= r;
    link_wdata_out <= d;
    repeat (2) @(posedge sys_clk_in);
    link_clk_out <= 1'b1;
    repeat (4) begin
      @(posedge sys_clk_in);
      if (rdata_valid_in === 1'b1) q = rdata_in;
    end
    link_clk_out <= 1'b0;
    @(posedge sys_clk_in);
    if (rdata_valid_in === 1'b1) q = rdata_in;
  endtask : op
  // Frame end: release, scramble data, idle gap
  task automatic done();
    @(posedge sys_clk_in);
    {link_sel_out, link_addr_out, link_wr_out, link_rd_out} <= 4'h0;
    link_wdata_out <= ~link_wdata_out;
    repeat (8) @(posedge sys_clk_in);
  endtask : done
endmodule : sensor_host_model

// ==== sensor_readout_pkg.sv ====
// ==========================================
// Register map and field layout
package sensor_readout_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_STATUS0 = 8'h00;
  localparam logic [7:0] ADDR_STATUS1 = 8'h01;
  localparam logic [7:0] ADDR_PROX = 8'h02;
  localparam logic [7:0] ADDR_LIGHT = 8'h04;
  localparam logic [7:0] LIGHT_BYTES = 8'h0f;
  localparam logic [7:0] ADDR_SET_FIRST = 8'h13;
  localparam logic [7:0] ADDR_SET_LAST = 8'h37;
  localparam logic [7:0] ADDR_CTRL_LIGHT = 8'h15;
  localparam logic [7:0] ADDR_CTRL_PULSE = 8'h16;
  localparam logic [7:0] ADDR_HIDDEN_A = 8'h19;
  localparam logic [7:0] ADDR_HIDDEN_B = 8'h2e;
  localparam logic [7:0] ADDR_HIDDEN_C = 8'h35;
  localparam logic [7:0] ADDR_WR_PTR = 8'h38;
  localparam logic [7:0] ADDR_RD_PTR = 8'h39;
  localparam logic [7:0] ADDR_OVF = 8'h3a;
  localparam logic [7:0] ADDR_DATA = 8'h3b;
  localparam logic [7:0] ADDR_TRIM_IR = 8'h42;
  localparam logic [7:0] ADDR_TRIM_RED = 8'h43;
  // Sizes
  localparam int SET_N = 37;
  localparam int LIGHT_CH = 5;
  localparam int DARK_CH = 4;
  localparam int CH_W = 24;
  localparam int SLOTS = 32;
  localparam int TRIM_FRAC = 7;
  localparam int LINK_W = 13;
  // Control bit positions
  localparam int EN_BIT = 0;
  localparam int PULSE_SEL_BIT = 1;
  localparam int DUAL_BIT = 2;
  localparam int RED_BIT = 3;
  localparam int SWRST_BIT = 7;
  localparam int POR_BIT = 7;
  // Status bit positions
  localparam int LIGHT_RDY_BIT = 0;
  localparam int PULSE_RDY_BIT = 4;
  localparam int PROX_RDY_BIT = 0;
  // Reset values
  localparam logic [7:0] RST_HIDDEN_A = 8'h02;
  localparam logic [7:0] RST_HIDDEN_B = 8'h09;
  localparam logic [7:0] RST_HIDDEN_C = 8'h00;
  localparam logic [7:0] RST_TRIM = 8'h80;
endpackage : sensor_readout_pkg
